// >>> rtl/tmps_pkg.sv
`default_nettype none
package tmps_pkg;
    localparam int NUM_PORTS = 10;
    localparam int NUM_TRUNKS = 8;
    localparam int NUM_SEL = 8;
    localparam logic [3:0] CPU_PORT = 4'h8;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FLOW_SA_LO = 8'h04;
    localparam logic [7:0] OFS_FLOW_SA_HI = 8'h08;
    localparam logic [7:0] OFS_FLOW_DA_LO = 8'h0C;
    localparam logic [7:0] OFS_FLOW_DA_HI = 8'h10;
    localparam logic [7:0] OFS_STATS = 8'h14;
    localparam logic [7:0] OFS_LAST_MAP = 8'h18;
    localparam logic [7:0] OFS_SEL_BASE = 8'h20;
    localparam logic [7:0] OFS_MEMB_BASE = 8'h40;
    // control register fields
    localparam int CTRL_HASH_LSB = 0;
    localparam int CTRL_RING = 2;
    localparam int CTRL_ADDR_DST = 3;
    localparam int CTRL_FLOW_EN = 4;
    localparam int CTRL_REV_EN = 5;
    localparam int CTRL_IMIR_EN = 6;
    localparam int CTRL_EMIR_EN = 7;
    localparam int CTRL_MON_LSB = 8;
    localparam int CTRL_IMP_LSB = 12;
    localparam int CTRL_EMP_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [9:0] MEMB_RESET = 10'h000;

    typedef enum logic [1:0] {
        TMPS_HASH_BOTH = 2'b00,
        TMPS_HASH_SA = 2'b01,
        TMPS_HASH_DA = 2'b10,
        TMPS_HASH_PORT = 2'b11
    } tmps_hash_mode_t;

    typedef struct packed {
        logic [47:0] src_mac;
        logic [47:0] dst_mac;
        logic [3:0] src_port;
        logic [3:0] dst_port;
        logic dst_in_trunk;
        logic [2:0] dst_trunk;
        logic multicast;
        logic src_mirror_flag;
        logic dst_mirror_flag;
        logic [9:0] vlan_map;
    } tmps_req_t;

    typedef struct packed {
        logic [9:0] port_map;
        logic [9:0] mirror_map;
        logic discard;
    } tmps_res_t;
endpackage
`default_nettype wire

// >>> rtl/tmps_select.sv
// How it works
// [R1] eight trunk groups, each with up to eight member ports
// [R2] selection entries may name any port, including a cascade link
// [R3] unicast hash on SA+DA, SA, DA, or source port in ring mode
// [R4] multicast uses the same hash mode as unicast
// [R5] software keeps all trunk members in the same VLAN maps
// [R6] software rewrites selection entries when a member link fails
// [R7] trunk flag in address entry picks the destination trunk group
// [R8] unicast from a member of the destination trunk is discarded
// [R9] hash key indexes eight per-trunk entries naming a member port
// [R10] hash is a pure function of header fields, flows stay ordered
// [R11] multicast candidates start from the VLAN member map
// [R12] multicast drops the ingress port and its whole trunk
// [R13] multicast keeps exactly one hash-selected member per trunk
// [R14] mirroring by address, by address pair, or by port
// [R15] address-table mirror flag, source or destination matched
// [R16] flagged source or destination address copies to mirror port
// [R17] flow mirroring copies frames matching the programmed pair
// [R18] reverse enable also copies the swapped address pair
// [R19] ingress or egress of a chosen port copied to a mirror port
// [R20] two mirror ports, one ingress, one egress
// [R21] mirror ports carry only mirrored copies
// [R22] ten ports, CPU port is number 8
// [R23] 3-bit hash key by xor folding the selected bits
// [R24] port map registered one cycle after a valid request
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module tmps_select #(
    parameter int PORTS = tmps_pkg::NUM_PORTS,
    parameter int TRUNKS = tmps_pkg::NUM_TRUNKS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // search result in
    input wire logic i_req_valid,
    input wire tmps_pkg::tmps_req_t i_req,
    // forwarding result out
    output logic o_res_valid,
    output tmps_pkg::tmps_res_t o_res
);
    logic [31:0] ctrl;
    logic [47:0] flow_sa;
    logic [47:0] flow_da;
    logic [31:0] sel_tab [TRUNKS];
    logic [PORTS-1:0] memb [TRUNKS];
    logic [15:0] frame_cnt;
    logic [15:0] discard_cnt;
    logic [PORTS-1:0] last_map;

    // bus address phase capture
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_ok;
    logic [31:0] rd_val;

    assign addr_ok = i_hsel && i_htrans[1] && i_hready;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && i_hwrite;
            wr_addr <= i_haddr[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_hreadyout <= 1'b0;
            o_hresp <= 1'b0;
            o_hrdata <= 32'h0000_0000;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            if (addr_ok && !i_hwrite) begin
                o_hrdata <= rd_val;
            end
        end
    end

    // per-trunk read decode
    genvar tv;
    logic [31:0] trk_rd [TRUNKS];
    generate
        for (tv = 0; tv < TRUNKS; tv++) begin : g_trk_rd
            assign trk_rd[tv] = (i_haddr[7:0] == tmps_pkg::OFS_SEL_BASE + 8'(4 * tv))
                                ? sel_tab[tv]
                                : (i_haddr[7:0] == tmps_pkg::OFS_MEMB_BASE + 8'(4 * tv))
                                ? {22'h000000, memb[tv]} : 32'h0000_0000;
        end
    endgenerate

    always_comb begin
        rd_val = 32'h0000_0000;
        case (i_haddr[7:0])
            tmps_pkg::OFS_CTRL: rd_val = ctrl;
            tmps_pkg::OFS_FLOW_SA_LO: rd_val = flow_sa[31:0];
            tmps_pkg::OFS_FLOW_SA_HI: rd_val = {16'h0000, flow_sa[47:32]};
            tmps_pkg::OFS_FLOW_DA_LO: rd_val = flow_da[31:0];
            tmps_pkg::OFS_FLOW_DA_HI: rd_val = {16'h0000, flow_da[47:32]};
            tmps_pkg::OFS_STATS: rd_val = {discard_cnt, frame_cnt};
            tmps_pkg::OFS_LAST_MAP: rd_val = {22'h000000, last_map};
            default: begin
                for (int g = 0; g < TRUNKS; g++) begin
                    rd_val = rd_val | trk_rd[g];
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl <= tmps_pkg::CTRL_RESET;
            flow_sa <= 48'h0000_0000_0000;
            flow_da <= 48'h0000_0000_0000;
        end else if (wr_pend) begin
            case (wr_addr)
                tmps_pkg::OFS_CTRL: ctrl <= i_hwdata;
                tmps_pkg::OFS_FLOW_SA_LO: flow_sa[31:0] <= i_hwdata;
                tmps_pkg::OFS_FLOW_SA_HI: flow_sa[47:32] <= i_hwdata[15:0];
                tmps_pkg::OFS_FLOW_DA_LO: flow_da[31:0] <= i_hwdata;
                tmps_pkg::OFS_FLOW_DA_HI: flow_da[47:32] <= i_hwdata[15:0];
                default: ;
            endcase
        end
    end

    // trunk tables, one pair of registers per group
    // [R1] eight groups of eight
    genvar gv;
    generate
        for (gv = 0; gv < TRUNKS; gv++) begin : g_trunk
            // [R6] software member update
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    sel_tab[gv] <= tmps_pkg::SEL_RESET;
                    memb[gv] <= tmps_pkg::MEMB_RESET;
                end else if (wr_pend) begin
                    if (wr_addr == tmps_pkg::OFS_SEL_BASE + 8'(4 * gv)) begin
                        sel_tab[gv] <= i_hwdata;
                    end
                    if (wr_addr == tmps_pkg::OFS_MEMB_BASE + 8'(4 * gv)) begin
                        memb[gv] <= i_hwdata[PORTS-1:0];
                    end
                end
            end
        end
    endgenerate

    // control fields
    logic [1:0] hash_mode;
    logic [3:0] mon_port;
    logic [3:0] imir_port;
    logic [3:0] emir_port;
    assign hash_mode = ctrl[tmps_pkg::CTRL_HASH_LSB +: 2];
    assign mon_port = ctrl[tmps_pkg::CTRL_MON_LSB +: 4];
    assign imir_port = ctrl[tmps_pkg::CTRL_IMP_LSB +: 4];
    assign emir_port = ctrl[tmps_pkg::CTRL_EMP_LSB +: 4];

    function automatic logic [2:0] fold3(input logic [47:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 16; i++) begin
            r = r ^ v[3*i +: 3];
        end
        return r;
    endfunction

    // [R22] ten numbered ports
    function automatic logic [PORTS-1:0] onehot(input logic [3:0] p);
        logic [PORTS-1:0] r;
        r = '0;
        for (int i = 0; i < PORTS; i++) begin
            r[i] = (p == 4'(i));
        end
        return r;
    endfunction

    // hash key
    logic [2:0] hkey;
    always_comb begin
        // [R3] hash mode choice
        case (tmps_pkg::tmps_hash_mode_t'(hash_mode))
            tmps_pkg::TMPS_HASH_SA: hkey = fold3(i_req.src_mac);
            tmps_pkg::TMPS_HASH_DA: hkey = fold3(i_req.dst_mac);
            tmps_pkg::TMPS_HASH_PORT: begin
                // source port only in ring mode
                if (ctrl[tmps_pkg::CTRL_RING]) begin
                    hkey = i_req.src_port[2:0] ^ {2'b00, i_req.src_port[3]};
                end else begin
                    hkey = fold3(i_req.src_mac ^ i_req.dst_mac);
                end
            end
            // [R23] xor fold key
            default: hkey = fold3(i_req.src_mac ^ i_req.dst_mac);
        endcase
    end

    // per-trunk selected member and source-trunk mask
    logic [PORTS-1:0] pick [TRUNKS];
    logic [PORTS-1:0] src_grp;
    logic [PORTS-1:0] src_bit;
    logic [PORTS-1:0] src_memb [TRUNKS];
    assign src_bit = onehot(i_req.src_port);
    generate
        for (tv = 0; tv < TRUNKS; tv++) begin : g_pick
            // [R2] entry may name any port
            // [R9] selection entry lookup
            assign pick[tv] = onehot(sel_tab[tv][4*hkey +: 4]);
            // [R12] source trunk members
            assign src_memb[tv] = ((memb[tv] & src_bit) != '0) ? memb[tv] : '0;
        end
    endgenerate
    always_comb begin
        src_grp = src_bit;
        for (int g = 0; g < TRUNKS; g++) begin
            src_grp = src_grp | src_memb[g];
        end
    end

    // forwarding map
    logic [PORTS-1:0] fwd;
    logic drop;
    always_comb begin
        fwd = '0;
        drop = 1'b0;
        if (i_req.multicast) begin
            // [R11] vlan candidates
            fwd = i_req.vlan_map;
            // [R12] remove source group
            fwd = fwd & ~src_grp;
            // [R4] [R13] one member per trunk
            for (int g = 0; g < TRUNKS; g++) begin
                if ((fwd & memb[g]) != '0) begin
                    fwd = (fwd & ~memb[g]) | pick[g];
                end
            end
        end else if (i_req.dst_in_trunk) begin
            // [R7] [R10] trunk member by hash
            fwd = pick[i_req.dst_trunk];
            // [R8] source in destination trunk
            if ((memb[i_req.dst_trunk] & src_bit) != '0) begin
                fwd = '0;
                drop = 1'b1;
            end
        end else begin
            fwd = onehot(i_req.dst_port);
        end
    end

    // mirror copies
    logic addr_hit;
    logic flow_hit;
    logic [PORTS-1:0] mir_ports;
    logic [PORTS-1:0] copies;
    always_comb begin
        // [R15] [R16] address mirror flag
        addr_hit = ctrl[tmps_pkg::CTRL_ADDR_DST] ? i_req.dst_mirror_flag
                                                  : i_req.src_mirror_flag;
        // [R17] flow pair match
        flow_hit = ctrl[tmps_pkg::CTRL_FLOW_EN]
                   && i_req.src_mac == flow_sa && i_req.dst_mac == flow_da;
        // [R18] reverse pair match
        if (ctrl[tmps_pkg::CTRL_FLOW_EN] && ctrl[tmps_pkg::CTRL_REV_EN]
            && i_req.src_mac == flow_da && i_req.dst_mac == flow_sa) begin
            flow_hit = 1'b1;
        end
        // [R20] two mirror ports
        mir_ports = '0;
        if (ctrl[tmps_pkg::CTRL_IMIR_EN]) begin
            mir_ports = mir_ports | onehot(imir_port);
        end
        if (ctrl[tmps_pkg::CTRL_EMIR_EN]) begin
            mir_ports = mir_ports | onehot(emir_port);
        end
        copies = '0;
        // [R14] [R19] ingress copy
        if (ctrl[tmps_pkg::CTRL_IMIR_EN]
            && (addr_hit || flow_hit || i_req.src_port == mon_port)) begin
            copies = copies | onehot(imir_port);
        end
        // [R19] egress copy
        if (ctrl[tmps_pkg::CTRL_EMIR_EN] && (fwd & onehot(mon_port)) != '0) begin
            copies = copies | onehot(emir_port);
        end
    end

    // registered result
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_res_valid <= 1'b0;
            o_res <= '0;
        end else begin
            // [R24] one cycle result
            o_res_valid <= i_req_valid;
            if (i_req_valid) begin
                // [R21] mirror ports excluded
                o_res.port_map <= (fwd & ~mir_ports) | copies;
                o_res.mirror_map <= copies;
                o_res.discard <= drop;
            end
        end
    end

    // status counters
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            frame_cnt <= 16'h0000;
            discard_cnt <= 16'h0000;
            last_map <= '0;
        end else if (i_req_valid) begin
            frame_cnt <= frame_cnt + 16'h0001;
            last_map <= (fwd & ~mir_ports) | copies;
            if (drop) begin
                discard_cnt <= discard_cnt + 16'h0001;
            end
        end
    end
endmodule // tmps_select
`default_nettype wire

// >>> tb/tmps_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
module tmps_engine_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // bench side
    input wire logic i_go,
    input wire tmps_pkg::tmps_req_t i_frame,
    // design side
    output logic o_req_valid,
    output tmps_pkg::tmps_req_t o_req,
    input wire logic i_res_valid,
    output logic [15:0] o_n_res
);
    // idle lines invert each cycle so stale fields are never reused
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_req_valid <= 1'b0;
            o_req <= '0;
            o_n_res <= 16'h0000;
        end else begin
            o_req_valid <= i_go;
            o_req <= i_go ? i_frame : ~o_req;
            o_n_res <= o_n_res + {15'h0000, i_res_valid};
        end
    end
endmodule // tmps_engine_model
`default_nettype wire

// >>> tb/tmps_select_sva.sv
`timescale 1ns/10ps
`default_nettype none
module tmps_select_sva (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // bus and frame ports
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic i_req_valid,
    input wire tmps_pkg::tmps_req_t i_req,
    input wire logic o_res_valid,
    input wire tmps_pkg::tmps_res_t o_res
);
    logic wp;
    logic mo;
    // mo: both mirror enables off
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wp <= 1'b0;
            mo <= 1'b1;
        end else if (i_hready) begin
            wp <= i_hsel && i_htrans[1] && i_hwrite && i_haddr[7:0] == 8'h00;
            if (wp) mo <= i_hwdata[7:6] == 2'b00;
        end
    end
    default clocking dc @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_uni;
        i_req_valid && !i_req.multicast && mo;
    endsequence
    sequence s_mc;
        i_req_valid && i_req.multicast && mo;
    endsequence
    a_res_follows: assert property (i_req_valid |=> o_res_valid)
        else $error("result strobe missing");
    a_res_pulse: assert property (!i_req_valid |=> !o_res_valid)
        else $error("result strobe without request");
    a_res_holds: assert property (!o_res_valid |-> $stable(o_res))
        else $error("result changed without strobe");
    a_uni_direct: assert property (s_uni ##0 !i_req.dst_in_trunk |=>
        o_res.port_map == (10'h001 << $past(i_req.dst_port)) && !o_res.discard)
        else $error("plain unicast map wrong");
    a_trunk_one: assert property (s_uni ##0 i_req.dst_in_trunk |=> $onehot0(o_res.port_map))
        else $error("trunk unicast not single port");
    a_drop_empty: assert property (o_res_valid && o_res.discard && mo |-> !(|o_res.port_map))
        else $error("discarded frame has ports");
    a_mc_ingress: assert property (s_mc |=> !o_res.port_map[$past(i_req.src_port)])
        else $error("multicast back to ingress");
    a_mc_in_vlan: assert property (s_mc |=> !(|(o_res.port_map & ~$past(i_req.vlan_map))))
        else $error("multicast outside vlan");
endmodule // tmps_select_sva
bind tmps_select tmps_select_sva u_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_res_valid(o_res_valid), .o_res(o_res));
`default_nettype wire

// >>> tb/trunk_mirror_port_select_bench.sv
`timescale 1ns/10ps
`default_nettype none
module trunk_mirror_port_select_bench;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic qv, rv, hrdy, hresp;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ctrl = 32'h0, a, b;
    logic [31:0] rnd = 32'h5A50_02FE;
    logic [31:0] sel [8] = '{default: 32'h0};
    logic [9:0] memb [8] = '{default: 10'h000};
    logic [47:0] fsa = 48'h1234_5678_9ABC, fda = 48'h0F0E_0D0C_0B0A;
    logic [15:0] n_res;
    tmps_pkg::tmps_req_t frm = '0, req, r;
    tmps_pkg::tmps_res_t res, lst;
    tmps_pkg::tmps_res_t q [$];
    int n_fail = 0, num_checks = 0, cyc = 0, n_sent = 0, n_drop = 0;
    logic [31:0] cfg [10] = '{32'h0, 32'h1, 32'h2, 32'h7, 32'h3, 32'h0006_72F0,
        32'h0006_72F8, 32'h0000_7150, 32'h0006_0380, 32'h0};
    tmps_select dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .i_req_valid(qv), .i_req(req), .o_res_valid(rv), .o_res(res));
    tmps_engine_model peer (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_go(go), .i_frame(frm),
        .o_req_valid(qv), .o_req(req), .i_res_valid(rv), .o_n_res(n_res));
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_res(input tmps_pkg::tmps_res_t e, input tmps_pkg::tmps_res_t g);
        chk_word("port_map", {22'h0, e.port_map}, {22'h0, g.port_map});
        chk_word("discard", {31'h0, e.discard}, {31'h0, g.discard});
        chk_word("mirror_map", {22'h0, e.mirror_map}, {22'h0, g.mirror_map});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    function automatic logic [31:0] nxt();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd;
    endfunction
    function automatic logic [9:0] oh(input logic [3:0] p);
        return (p < 4'hA) ? 10'h001 << p : 10'h000;
    endfunction
    // xor fold of sixteen 3-bit slices
    function automatic logic [2:0] fold3(input logic [47:0] v);
        logic [2:0] k;
        k = 3'h0;
        for (int i = 0; i < 16; i++) begin
            k ^= v[3*i +: 3];
        end
        return k;
    endfunction
    function automatic tmps_pkg::tmps_res_t expect_res(input tmps_pkg::tmps_req_t f);
        logic [2:0] k;
        logic [9:0] fw, mi;
        logic ic;
        tmps_pkg::tmps_res_t e;
        e = '0;
        k = fold3(f.src_mac ^ f.dst_mac);
        if (ctrl[1:0] == 2'b01) k = fold3(f.src_mac);
        if (ctrl[1:0] == 2'b10) k = fold3(f.dst_mac);
        if (ctrl[2:0] == 3'b111) k = f.src_port[2:0] ^ {2'b00, f.src_port[3]};
        fw = oh(f.dst_port);
        if (f.dst_in_trunk) begin
            e.discard = memb[f.dst_trunk][f.src_port];
            fw = e.discard ? 10'h000 : oh(sel[f.dst_trunk][4*k +: 4]);
        end
        if (f.multicast) begin
            e.discard = 1'b0;
            fw = f.vlan_map & ~oh(f.src_port);
            for (int g = 0; g < 8; g++) begin
                if (memb[g][f.src_port]) fw &= ~memb[g];
            end
            for (int g = 0; g < 8; g++) begin
                if ((fw & memb[g]) != 10'h000) fw = (fw & ~memb[g]) | oh(sel[g][4*k +: 4]);
            end
        end
        ic = ctrl[6] && ((ctrl[3] ? f.dst_mirror_flag : f.src_mirror_flag)
            || f.src_port == ctrl[11:8] || (ctrl[4] && f.src_mac == fsa && f.dst_mac == fda)
            || (ctrl[4] && ctrl[5] && f.src_mac == fda && f.dst_mac == fsa));
        // mirror ports drop out of regular forwarding
        mi = (ctrl[6] ? oh(ctrl[15:12]) : 10'h000) | (ctrl[7] ? oh(ctrl[19:16]) : 10'h000);
        e.mirror_map = ic ? oh(ctrl[15:12]) : 10'h000;
        if (ctrl[7] && fw[ctrl[11:8]]) e.mirror_map |= oh(ctrl[19:16]);
        e.port_map = (fw & ~mi) | e.mirror_map;
        return e;
    endfunction
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge i_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        do @(posedge i_clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : nxt();
        do @(posedge i_clk); while (hrdy !== 1'b1);
        if (!wr) chk_word("hrdata", d, hrdata);
        chk_word("hresp", 32'h0, {31'h0, hresp});
        if (wr && ad == 8'h00) ctrl = d;
        if (wr && ad[7:5] == 3'b001) sel[ad[4:2]] = d;
        if (wr && ad[7:5] == 3'b010) memb[ad[4:2]] = d[9:0];
    endtask
    task automatic frames(input int n);
        for (int i = 0; i < n; i++) begin
            a = nxt();
            b = nxt();
            r = {a, b, nxt(), a[24:0]};
            r.src_port = a[7:4] % 4'hA;
            r.dst_port = a[11:8] % 4'hA;
            r.dst_trunk[2:1] = 2'b00;
            if (a[13:12] == 2'b01) {r.src_mac, r.dst_mac} = {fsa, fda};
            if (a[13:12] == 2'b10) {r.src_mac, r.dst_mac} = {fda, fsa};
            // a vlan holds every member of a trunk it touches
            for (int g = 0; g < 8; g++) begin
                if ((r.vlan_map & memb[g]) != 10'h000) r.vlan_map |= memb[g];
            end
            lst = expect_res(r);
            n_drop += lst.discard;
            q.push_back(lst);
            @(posedge i_clk);
            go <= 1'b1;
            frm <= r;
            n_sent++;
        end
        @(posedge i_clk);
        go <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (rv === 1'b1 && q.size() == 0) chk_word("spare result", 32'h0, 32'h1);
        if (rv === 1'b1 && q.size() > 0) chk_res(q.pop_front(), res);
        if (cyc == 3000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        bus(1'b0, tmps_pkg::OFS_CTRL, tmps_pkg::CTRL_RESET);
        bus(1'b0, tmps_pkg::OFS_SEL_BASE, tmps_pkg::SEL_RESET);
        bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
        bus(1'b0, 8'hFC, 32'h0);
        bus(1'b1, 8'h40, 32'h007);
        bus(1'b1, 8'h44, 32'h018);
        bus(1'b1, 8'h20, 32'h1021_0210);
        bus(1'b1, 8'h24, 32'h3434_4343);
        bus(1'b0, 8'h20, 32'h1021_0210);
        bus(1'b1, 8'h04, fsa[31:0]);
        bus(1'b1, 8'h08, {16'h0, fsa[47:32]});
        bus(1'b1, 8'h0C, fda[31:0]);
        bus(1'b1, 8'h10, {16'h0, fda[47:32]});
        foreach (cfg[c]) begin
            bus(1'b1, 8'h00, cfg[c]);
            bus(1'b0, 8'h00, cfg[c]);
            // member 0 down, software moves its keys
            if (c == 9) bus(1'b1, 8'h20, 32'h2121_2121);
            frames(14);
        end
        chk_word("open notes", 32'h0, 32'(q.size()));
        chk_word("results", 32'(n_sent), {16'h0, n_res});
        bus(1'b0, tmps_pkg::OFS_STATS, {16'(n_drop), 16'(n_sent)});
        bus(1'b0, tmps_pkg::OFS_LAST_MAP, {22'h0, lst.port_map});
        complete_run();
    end
endmodule // trunk_mirror_port_select_bench
`default_nettype wire
